/* rtl/reset_irq_vector_locator.sv */
// reset and interrupt vector locator: picks the fetch address after reset
// and for the lowest pending request; assumes the core drops its global
// enable on taking a vector and that peripherals clear a flag on ack
`timescale 1ns/10ps

// Summary of operation
// - any reset source starts execution at word zero unless boot relocation applies.
// - external requests 0, 1, 2 vector to 0x0002, 0x0004, 0x0006 past base.
// - pin-change requests 0 to 3 vector to slots 0x0008 through 0x000e.
// - watchdog time-out vectors to 0x0010 past the table base.
// - timer 2 match a, match b, wrap vector to 0x0012, 0x0014, 0x0016.
// - timer 1 capture, match a, match b, wrap use slots 0x0018 to 0x001e.
// - timer 0 match a, match b, wrap vector to 0x0020, 0x0022, 0x0024.
// - spi transfer done vectors to 0x0026 past the table base.
// - serial 0 receive, empty, transmit vector to 0x0028, 0x002a, 0x002c.
// - comparator, converter, eeprom, two-wire use slots 0x002e to 0x0034.
// - self-program ready vectors to 0x0036 past the table base.
// - serial 1 receive, empty, transmit vector to 0x0038, 0x003a, 0x003c.
// - programmed boot-reset fuse starts execution at the boot section start.
// - vector-select set adds the boot section start to every slot.
// - reset address and vector base are chosen independently by fuse and select bit.
// - boot section start follows the boot-size fuses.
// - with vector-select clear the vectors sit at the start of flash.
module reset_irq_vector_locator
   import vec_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_boot_reset_fuse,
   input wire logic [1:0] i_boot_size_fuses,
   input wire logic i_vector_table_in_boot,
   input wire logic i_global_irq_en,
   input wire irq_req_s i_irq_req,
   output logic o_fetch_valid,
   output fetch_s o_fetch,
   output irq_req_s o_irq_ack
);

   //***************************************
   // fuse synchroniser
   //***************************************
   logic [FUSE_W-1:0] sync1_ff;
   logic [FUSE_W-1:0] sync2_ff;
   logic [FUSE_W-1:0] sync3_ff;
   logic [FUSE_W-1:0] nxt_sync1;
   logic [FUSE_W-1:0] nxt_sync2;
   logic [FUSE_W-1:0] nxt_sync3;
   logic fuse_agree;

   always_comb begin
      nxt_sync1 = {i_boot_size_fuses, i_boot_reset_fuse};
      nxt_sync2 = sync1_ff;
      nxt_sync3 = sync2_ff;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync1_ff <= FUSE_RST;
         sync2_ff <= FUSE_RST;
         sync3_ff <= FUSE_RST;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         sync3_ff <= nxt_sync3;
      end
   end

   // only the later two stages are compared; the first may be metastable
   assign fuse_agree = (sync2_ff == sync3_ff);

   //***************************************
   // request priority
   //***************************************
   logic [VEC_COUNT-1:0] req_bits;
   logic [VEC_COUNT:0] lower_any;
   logic [VEC_COUNT-1:0] hit;
   logic [IDX_W-1:0] pick_idx;

   assign req_bits = i_irq_req;
   assign lower_any[0] = 1'b0;

   generate
      for (genvar g = 0; g < VEC_COUNT; g++) begin : g_prio
         assign lower_any[g+1] = lower_any[g] | req_bits[g];
         assign hit[g] = req_bits[g] & ~lower_any[g];
      end
   endgenerate

   always_comb begin
      pick_idx = '0;
      for (int i = 0; i < VEC_COUNT; i++) begin
         if (hit[i]) begin
            pick_idx = IDX_W'(i);
         end
      end
   end

   //***************************************
   // sequencer and fetch output
   //***************************************
   loc_state_e state_ff;
   loc_state_e nxt_state;
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;
   logic [FUSE_W-1:0] fuse_ff;
   logic [FUSE_W-1:0] nxt_fuse;
   logic [ADDR_W-1:0] boot_addr_ff;
   logic [ADDR_W-1:0] nxt_boot_addr;
   logic valid_ff;
   logic nxt_valid;
   fetch_s fetch_ff;
   fetch_s nxt_fetch;
   logic [VEC_COUNT-1:0] ack_ff;
   logic [VEC_COUNT-1:0] nxt_ack;
   logic [ADDR_W-1:0] vec_base;

   // interrupt base chosen by the select bit alone
   assign vec_base = i_vector_table_in_boot ? boot_addr_ff : APP_BASE;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_fuse = fuse_ff;
      nxt_boot_addr = boot_addr_ff;
      nxt_valid = 1'b0;
      nxt_fetch = fetch_ff;
      nxt_ack = '0;
      unique case (state_ff)
         ST_SETTLE: begin
            // wait for the fuse pins to pass the synchroniser and agree
            if (cnt_ff != SETTLE_CNT) begin
               nxt_cnt = cnt_ff + 2'h1;
            end else if (fuse_agree) begin
               nxt_fuse = sync3_ff;
               nxt_boot_addr = BOOT_ADDR_SZ[sync3_ff[FUSE_SZ_LSB +: 2]];
               nxt_state = ST_RESET;
            end
         end
         ST_RESET: begin
            nxt_valid = 1'b1;
            nxt_fetch.vno = RESET_VNO;
            nxt_fetch.is_reset = 1'b1;
            // fuse high (unprogrammed) keeps word zero
            if (fuse_ff[FUSE_BRST_BIT]) begin
               nxt_fetch.addr = RESET_ADDR;
            end else begin
               nxt_fetch.addr = boot_addr_ff;
            end
            nxt_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (i_global_irq_en && (|req_bits)) begin
               nxt_valid = 1'b1;
               nxt_fetch.vno = FIRST_IRQ_VNO + pick_idx;
               nxt_fetch.is_reset = 1'b0;
               nxt_fetch.addr = vec_base + VEC_TABLE[pick_idx];
               nxt_ack = hit;
               nxt_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // a still-set enable would re-vector the same request twice
            if (!i_global_irq_en) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_ff <= ST_SETTLE;
         cnt_ff <= '0;
         fuse_ff <= FUSE_RST;
         boot_addr_ff <= BOOT_ADDR_SZ[0];
         valid_ff <= 1'b0;
         fetch_ff <= '0;
         ack_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         fuse_ff <= nxt_fuse;
         boot_addr_ff <= nxt_boot_addr;
         valid_ff <= nxt_valid;
         fetch_ff <= nxt_fetch;
         ack_ff <= nxt_ack;
      end
   end

   assign o_fetch_valid = valid_ff;
   assign o_fetch = fetch_ff;
   assign o_irq_ack = ack_ff;

   //***************************************
   // checks
   //***************************************
   logic in_boot_q_ff;
   logic [ADDR_W-1:0] base_q;
   logic [ADDR_W-1:0] slot_off;
   logic irq_out;

   always_ff @(posedge i_clk_sys) begin
      in_boot_q_ff <= i_vector_table_in_boot;
   end

   assign base_q = in_boot_q_ff ? boot_addr_ff : APP_BASE;
   assign slot_off = ADDR_W'({fetch_ff.vno - RESET_VNO, 1'b0});
   assign irq_out = valid_ff && !fetch_ff.is_reset;

   a_reset_app_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      valid_ff && fetch_ff.is_reset && fuse_ff[FUSE_BRST_BIT] |-> fetch_ff.addr == 16'h0000)
      else $error("reset vector not at word zero");
   a_ext_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h02:5'h04]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("external request slot wrong");
   a_pin_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h05:5'h08]} |-> fetch_ff.addr - base_q == slot_off)
      else $error("pin change slot wrong");
   a_wdog_slot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno == 5'h09 |-> fetch_ff.addr == base_q + 16'h0010)
      else $error("watchdog slot wrong");
   a_t2_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h0a:5'h0c]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("timer 2 slot wrong");
   a_t1_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h0d:5'h10]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("timer 1 slot wrong");
   a_t0_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h11:5'h13]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("timer 0 slot wrong");
   a_spi_slot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno == 5'h14 |-> fetch_ff.addr == base_q + 16'h0026)
      else $error("spi slot wrong");
   a_ser0_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h15:5'h17]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("serial 0 slot wrong");
   a_misc_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h18:5'h1b]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("analog or two-wire slot wrong");
   a_spm_slot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno == 5'h1c |-> fetch_ff.addr == base_q + 16'h0036)
      else $error("self program slot wrong");
   a_ser1_slots: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && fetch_ff.vno inside {[5'h1d:5'h1f]} |-> fetch_ff.addr == base_q + slot_off)
      else $error("serial 1 slot wrong");
   a_reset_boot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      valid_ff && fetch_ff.is_reset && !fuse_ff[FUSE_BRST_BIT] |-> fetch_ff.addr == boot_addr_ff)
      else $error("boot reset address not used");
   a_vec_moved: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && in_boot_q_ff |-> fetch_ff.addr == boot_addr_ff + slot_off)
      else $error("vectors not moved to boot section");
   a_reset_once: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(valid_ff && fetch_ff.is_reset) |=> !(valid_ff && fetch_ff.is_reset) [*8])
      else $error("reset vector repeated");
   a_boot_size: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_ff != ST_SETTLE |-> boot_addr_ff == BOOT_ADDR_SZ[fuse_ff[FUSE_SZ_LSB +: 2]])
      else $error("boot start does not follow size fuses");
   a_vec_app: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out && !in_boot_q_ff |-> fetch_ff.addr == slot_off)
      else $error("vectors not at start of flash");
   a_lowest_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out |-> $onehot(ack_ff) && ((($past(req_bits) & (ack_ff - 30'h1))) == '0)
         && ack_ff[fetch_ff.vno - FIRST_IRQ_VNO])
      else $error("served request is not the lowest pending");
   a_serve_prompt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_ff == ST_IDLE && i_global_irq_en && (|req_bits) |=> valid_ff && !fetch_ff.is_reset)
      else $error("pending request not served next cycle");

   //***************************************
   // output protocol checks
   //***************************************
   // an ack without a fetch would clear a flag whose vector the core never saw
   a_ack_with_fetch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      ack_ff != '0 |-> irq_out && $onehot(ack_ff))
      else $error("ack without interrupt fetch");
   a_reset_no_ack: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      valid_ff && fetch_ff.is_reset |-> ack_ff == '0 && fetch_ff.vno == RESET_VNO)
      else $error("reset fetch carries an ack or wrong number");
   a_settle_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_ff == ST_SETTLE |-> !valid_ff)
      else $error("fetch before fuses were latched");
   a_gated_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_global_irq_en |=> !irq_out)
      else $error("interrupt served while enable low");
   // the hold state keeps one source from being served twice before its flag drops
   a_one_per_enable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      irq_out |=> !valid_ff)
      else $error("back-to-back vectors without enable low");
   a_hold_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_ff == ST_HOLD && !i_global_irq_en |=> state_ff == ST_IDLE)
      else $error("hold not left after enable low");
   // reset is synchronous, so cleared outputs show one edge after it is seen
   a_reset_quiet: assert property (@(posedge i_clk_sys)
      i_rst |=> !valid_ff && ack_ff == '0 && fetch_ff == '0)
      else $error("outputs not cleared by reset");

endmodule : reset_irq_vector_locator

/* rtl/vec_pkg.sv */
// constants, carriers and states for the reset and interrupt vector locator
// assumes word-addressed program memory and requests from logic on the core clock
package vec_pkg;

   localparam int VEC_COUNT = 30;
   localparam int ADDR_W = 16;
   localparam int VNO_W = 5;
   localparam int IDX_W = 5;

   localparam logic [15:0] RESET_ADDR = 16'h0000;
   localparam logic [15:0] APP_BASE = 16'h0000;
   localparam logic [4:0] RESET_VNO = 5'h01;
   localparam logic [4:0] FIRST_IRQ_VNO = 5'h02;

   // boot section start per boot-size fuse code; plain defaults, set per memory size
   localparam logic [15:0] BOOT_ADDR_SZ [4] = '{16'h7000, 16'h7800, 16'h7c00, 16'h7e00};

   // slot offset per request, index 0 is vector number 2
   localparam logic [15:0] VEC_TABLE [VEC_COUNT] = '{
      16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
      16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018,
      16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
      16'h0026, 16'h0028, 16'h002a, 16'h002c, 16'h002e, 16'h0030,
      16'h0032, 16'h0034, 16'h0036, 16'h0038, 16'h003a, 16'h003c};

   // fuse pins: {boot_size_fuses[1:0], boot_reset_fuse}
   localparam int FUSE_W = 3;
   localparam logic [2:0] FUSE_RST = 3'h1;
   localparam int FUSE_BRST_BIT = 0;
   localparam int FUSE_SZ_LSB = 1;
   localparam logic [1:0] SETTLE_CNT = 2'h3;

   typedef struct packed {
      logic serial1_tx_done_req;
      logic serial1_tx_empty_req;
      logic serial1_rx_done_req;
      logic self_program_ready_req;
      logic two_wire_req;
      logic eeprom_ready_req;
      logic adc_done_req;
      logic comparator_req;
      logic serial0_tx_done_req;
      logic serial0_tx_empty_req;
      logic serial0_rx_done_req;
      logic spi_done_req;
      logic t0_wrap_req;
      logic t0_match_b_req;
      logic t0_match_a_req;
      logic t1_wrap_req;
      logic t1_match_b_req;
      logic t1_match_a_req;
      logic t1_capture_req;
      logic t2_wrap_req;
      logic t2_match_b_req;
      logic t2_match_a_req;
      logic watchdog_timeout_req;
      logic pin_change_req_3;
      logic pin_change_req_2;
      logic pin_change_req_1;
      logic pin_change_req_0;
      logic ext_request_2;
      logic ext_request_1;
      logic ext_request_0;
   } irq_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [4:0] vno;
      logic is_reset;
   } fetch_s;

   typedef enum logic [3:0] {
      ST_SETTLE = 4'b0001,
      ST_RESET = 4'b0010,
      ST_IDLE = 4'b0100,
      ST_HOLD = 4'b1000
   } loc_state_e;

endpackage : vec_pkg

/* testbench/core_side_model.sv */
// partner model: peripheral request flags and the core's global enable
// assumes acks are one-cycle pulses and fetch_valid marks a taken vector
`timescale 1ns/10ps
module core_side_model
   import vec_pkg::*;
#(
   parameter int GAP = 3
)(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire irq_req_s i_set_req,
   input wire logic i_en_want,
   input wire logic i_fetch_valid,
   input wire irq_req_s i_irq_ack,
   output irq_req_s o_irq_req,
   output logic o_global_irq_en
);
   // ****************
   // flags and enable
   // ****************
   irq_req_s flags_ff;
   irq_req_s nxt_flags;
   logic [3:0] gap_ff;
   logic [3:0] nxt_gap;
   always_comb begin
      // only sources the bench raises are pending
      nxt_flags = irq_req_s'((flags_ff | i_set_req) & ~i_irq_ack);
      nxt_gap = (gap_ff != 4'h0) ? gap_ff - 4'h1 : 4'h0;
      // handler entry holds enable low for a while, slow on purpose
      if (i_fetch_valid) begin
         nxt_gap = 4'(GAP);
      end
      if (i_rst) begin
         nxt_flags = '0;
         nxt_gap = 4'h0;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      flags_ff <= nxt_flags;
      gap_ff <= nxt_gap;
   end
   assign o_irq_req = flags_ff;
   assign o_global_irq_en = i_en_want & (gap_ff == 4'h0);
endmodule : core_side_model

/* testbench/tb_top.sv */
// testbench for the vector locator: reset entries, every slot, relocation
// assumes core_side_model stands in for the core and the peripherals
`timescale 1ns/10ps
module tb_top;
   import vec_pkg::*;
   logic clk_sys, rst, fuse, in_boot, en_want, fetch_valid, gen;
   logic [1:0] sz;
   irq_req_s set_req, irq_req, ack;
   fetch_s fetch;
   int checks = 0;
   int fails = 0;
   reset_irq_vector_locator i_reset_irq_vector_locator (.i_clk_sys(clk_sys),
      .i_rst(rst), .i_boot_reset_fuse(fuse), .i_boot_size_fuses(sz),
      .i_vector_table_in_boot(in_boot), .i_global_irq_en(gen), .i_irq_req(irq_req),
      .o_fetch_valid(fetch_valid), .o_fetch(fetch), .o_irq_ack(ack));
   core_side_model i_core_side_model (.i_clk_sys(clk_sys), .i_rst(rst),
      .i_set_req(set_req), .i_en_want(en_want), .i_fetch_valid(fetch_valid),
      .i_irq_ack(ack), .o_irq_req(irq_req), .o_global_irq_en(gen));
   // *******
   // helpers
   // *******
   task automatic cmp_fetch(input fetch_s got, input fetch_s exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t fetch got 0x%h exp 0x%h", $time, got, exp);
      end
   endtask : cmp_fetch
   task automatic cmp_ack(input irq_req_s got, input irq_req_s exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t ack got 0x%h exp 0x%h", $time, got, exp);
      end
   endtask : cmp_ack
   task automatic wait_fetch(output logic seen);
      seen = 1'b0;
      for (int n = 0; n < 24 && !seen; n++) begin
         @(posedge clk_sys);
         #1;
         seen = (fetch_valid === 1'b1);
      end
      if (!seen) begin
         fails++;
         $display("[ERR] %0t fetch got 0x0 exp 0x1", $time);
      end
   endtask : wait_fetch
   task automatic raise(input int k);
      @(posedge clk_sys);
      set_req <= irq_req_s'(30'h1 << k);
      @(posedge clk_sys);
      set_req <= '0;
   endtask : raise
   task automatic take(input int k, input logic [15:0] base);
      logic seen;
      fetch_s ef;
      ef = '{addr: base + 16'(2 * (k + 1)), vno: 5'(k + 2), is_reset: 1'b0};
      wait_fetch(seen);
      if (seen) begin
         cmp_fetch(fetch, ef);
         cmp_ack(ack, irq_req_s'(30'h1 << k));
      end
   endtask : take
   // *********
   // scenarios
   // *********
   task automatic reset_entry(input logic f, input logic [1:0] s, input logic iv);
      logic seen;
      logic [15:0] boot;
      boot = BOOT_ADDR_SZ[s];
      @(posedge clk_sys);
      rst <= 1'b1;
      fuse <= f;
      sz <= s;
      in_boot <= iv;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      wait_fetch(seen);
      if (seen) begin
         cmp_fetch(fetch, '{addr: f ? 16'h0000 : boot, vno: 5'h01, is_reset: 1'b1});
         cmp_ack(ack, '0);
      end
      raise(0);
      take(0, iv ? boot : 16'h0000);
      raise(29);
      take(29, iv ? boot : 16'h0000);
      $display("reset entry fuse %0d size %0d select %0d done", f, s, iv);
   endtask : reset_entry
   task automatic sweep(input logic [15:0] base);
      for (int k = 0; k < 30; k++) begin
         raise(k);
         take(k, base);
      end
      $display("sweep of all slots at 0x%h done", base);
   endtask : sweep
   task automatic lowest_first();
      int order [3] = '{2, 5, 17};
      @(posedge clk_sys);
      en_want <= 1'b0;
      set_req <= irq_req_s'(30'h20024);
      @(posedge clk_sys);
      set_req <= '0;
      // nothing may be served while the core holds enable low
      repeat (8) begin
         @(posedge clk_sys);
         #1;
         cmp_ack(ack, '0);
      end
      @(posedge clk_sys);
      en_want <= 1'b1;
      foreach (order[i]) begin
         take(order[i], 16'h0000);
      end
      $display("lowest number first done");
   endtask : lowest_first
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   // ****
   // main
   // ****
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      $display("[ERR] %0t watchdog got 0x1 exp 0x0", $time);
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      fuse = 1'b1;
      sz = 2'h0;
      in_boot = 1'b0;
      en_want = 1'b1;
      set_req = '0;
      reset_entry(1'b1, 2'h0, 1'b0);
      sweep(16'h0000);
      for (int s = 0; s < 4; s++) begin
         reset_entry(1'b0, 2'(s), 1'b1);
      end
      sweep(BOOT_ADDR_SZ[3]);
      reset_entry(1'b1, 2'h2, 1'b1);
      reset_entry(1'b0, 2'h1, 1'b0);
      lowest_first();
      tally_and_finish();
   end
endmodule : tb_top
